/* File: core/mbt_consts.vh */
// Constants of the request handler: frame field positions, function codes,
// exception codes, limits and timing figures.
// Assumes it is included by bare name from the design files that need it.
`ifndef MBT_CONSTS_VH
`define MBT_CONSTS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define MBT_CLK_HZ 125000000
`define MBT_IDLE_TIMEOUT_S 60
`define MBT_TICK_CYCLES 17'h1E848
`define MBT_IDLE_MS 16'hEA60

// ****************************************************************
// Frame layout (byte positions from the first header byte)
// ****************************************************************
`define MBT_POS_TID_HI 8'h00
`define MBT_POS_TID_LO 8'h01
`define MBT_POS_PID_HI 8'h02
`define MBT_POS_PID_LO 8'h03
`define MBT_POS_LEN_HI 8'h04
`define MBT_POS_LEN_LO 8'h05
`define MBT_POS_UNIT 8'h06
`define MBT_POS_FC 8'h07
`define MBT_POS_W0_HI 8'h08
`define MBT_POS_W0_LO 8'h09
`define MBT_POS_W1_HI 8'h0A
`define MBT_POS_W1_LO 8'h0B
`define MBT_POS_BC 8'h0C
`define MBT_POS_WDATA 8'h0D
`define MBT_POS_RDATA 8'h09
`define MBT_HDR_TAIL 16'h0006
`define MBT_MIN_LEN 16'h0002

// ****************************************************************
// Header values, function codes, exception codes
// ****************************************************************
`define MBT_PROTO_ID 16'h0000
`define MBT_UNIT_ID 8'h01
`define MBT_FC_READ 8'h03
`define MBT_FC_WRITE 8'h10
`define MBT_FC_ACQ_CTL 8'h46
`define MBT_FC_ACQ_GET 8'h47
`define MBT_EXC_FLAG 8'h80
`define MBT_EXC_FUNC 8'h01
`define MBT_EXC_ADDR 8'h02
`define MBT_EXC_COUNT 8'h03

// ****************************************************************
// Limits and lengths
// ****************************************************************
`define MBT_READ_MAX 16'h0064
`define MBT_WRITE_MAX 16'h0032
`define MBT_MAP_WORDS 17'h003E8
`define MBT_BUF_WORDS 100
`define MBT_ACQ_START 16'h0001
`define MBT_ACQ_STOP 16'h0002
`define MBT_READ_REQ_LEN 16'h0006
`define MBT_WRITE_REQ_TAIL 16'h0007
`define MBT_READ_RSP_TAIL 16'h0003
`define MBT_WRITE_RSP_LEN 16'h0006
`define MBT_ACQ_LEN 16'h0004
`define MBT_EXC_LEN 16'h0003

`endif

/* File: core/mbt_idle_timer.v */
// Idle timer: closes the connection after a long spell without requests.
// Assumes activity_i pulses once per complete request frame, on the same clock.
`timescale 1ns/10ps
`include "mbt_consts.vh"

module mbt_idle_timer #(
  parameter [16:0] TICK_CYCLES = `MBT_TICK_CYCLES,
  parameter [15:0] IDLE_MS = `MBT_IDLE_MS
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire conn_up_i,
  input wire activity_i,
  output wire close_o
);

  // ****************************************************************
  // Millisecond divider and idle count
  // ****************************************************************
  reg [16:0] div_r; // Cycles within the current millisecond.
  reg [15:0] ms_r; // Whole milliseconds since the last request.
  reg fired_r; // Set once the close has been asked for.
  reg close_r; // One-cycle close request.

  assign close_o = close_r;

  // The count restarts on every request and while no connection exists; one
  // close pulse per idle spell, so a slow stack is not flooded with requests.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= 17'h00000;
      ms_r <= 16'h0000;
      fired_r <= 1'b0;
      close_r <= 1'b0;
    end else begin
      close_r <= 1'b0;
      if (!conn_up_i || activity_i) begin
        div_r <= 17'h00000;
        ms_r <= 16'h0000;
        fired_r <= 1'b0;
      end else if (div_r == TICK_CYCLES - 17'h00001) begin
        div_r <= 17'h00000;
        if (ms_r == IDLE_MS - 16'h0001) begin
          ms_r <= 16'h0000;
          if (!fired_r) begin
            close_r <= 1'b1;
          end
          fired_r <= 1'b1;
        end else begin
          ms_r <= ms_r + 16'h0001;
        end
      end else begin
        div_r <= div_r + 17'h00001;
      end
    end
  end

endmodule

/* File: core/mbt_request_handler.v */
// Request decoder and response builder for framed register-access requests.
// Assumes a byte stream from a TCP stack on the same clock, one frame per request
// marked by a last flag, and a register space answering a read one cycle later.
//
// Overview of operation
// - Codes 03, 16, 70, 71 form the command set.
// - Read returns consecutive registers from start number.
// - Read count above 100 is out of range.
// - Read reply: code, byte count 2n, length 2n+3.
// - Write stores words to consecutive registers.
// - Write count above 50 is out of range.
// - Out-of-range value dropped, normal reply still sent.
// - Control selection 0001 starts, 0002 stops acquisition.
// - Bad body: no action, exception reply length 3.
// - Exception function code is request code plus 80.
// - Exception codes: 01 function, 02 number, 03 count.
// - Bad header: no processing, no reply.
// - No connection: no processing, no reply.
// - Start number is reference number minus 40001.
// - Echo transaction id; reply with unit id 1.
// - Close connection after 60 s without requests.
`timescale 1ns/10ps
`include "mbt_consts.vh"

module mbt_request_handler #(
  parameter [16:0] TICK_CYCLES = `MBT_TICK_CYCLES,
  parameter [15:0] IDLE_MS = `MBT_IDLE_MS
) (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire conn_up_i,
  input wire [7:0] rx_data_i,
  input wire rx_valid_i,
  input wire rx_last_i,
  output wire rx_ready_o,
  output wire [7:0] tx_data_o,
  output wire tx_valid_o,
  output wire tx_last_o,
  input wire tx_ready_i,
  output wire [15:0] reg_addr_o,
  output wire reg_rd_o,
  input wire [15:0] reg_rdata_i,
  output wire reg_wr_o,
  output wire [15:0] reg_wdata_o,
  input wire reg_value_ok_i,
  output wire acq_start_o,
  output wire acq_stop_o,
  output wire acq_fetch_o,
  output wire conn_close_o
);

  // ****************************************************************
  // Reset release and state codes
  // ****************************************************************
  localparam [4:0] S_RX = 5'h01;
  localparam [4:0] S_CHK = 5'h02;
  localparam [4:0] S_FETCH = 5'h04;
  localparam [4:0] S_WRITE = 5'h08;
  localparam [4:0] S_SEND = 5'h10;

  reg rst_q1_r; // First reset stage, read only by the second.
  reg rst_n_r; // Released reset used by the sequencer and the idle timer.

  // Assertion is immediate, release waits two edges to avoid recovery hazards.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n_r <= rst_q1_r;
    end
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg [4:0] state_r; // One-hot sequencer state.
  reg [7:0] cnt_r; // Bytes of the frame received, saturating.
  reg drop_r; // Frame seen while the connection was down.
  reg [15:0] tid_r; // Transaction identifier.
  reg [15:0] pid_r; // Protocol identifier.
  reg [15:0] len_r; // Header length field.
  reg [7:0] unit_r; // Unit identifier.
  reg [7:0] fc_r; // Function code.
  reg [15:0] w0_r; // Start number or function selection.
  reg [15:0] w1_r; // Register count.
  reg [7:0] bc_r; // Write byte count.
  reg [15:0] buf_r [0:`MBT_BUF_WORDS-1]; // Write data or read results.
  reg exc_r; // Answer is an exception.
  reg [7:0] code_r; // Exception code.
  reg [6:0] k_r; // Word index of the register walk.
  reg [15:0] addr_r; // Register number presented.
  reg [15:0] wdata_r; // Word presented for writing.
  reg rd_r; // Read strobe.
  reg rd_q_r; // Read data due this cycle.
  reg wr_r; // Write slot.
  reg [6:0] cap_r; // Buffer slot of the read data due.
  reg [7:0] t_r; // Index of the next response byte.
  reg [7:0] tx_byte_r; // Response byte on the stream.
  reg tx_valid_r; // Response byte valid.
  reg tx_last_r; // Last byte of the response.
  reg start_r; // Acquisition start pulse.
  reg stop_r; // Acquisition stop pulse.
  reg fetch_r; // Acquisition data request pulse.

  wire rx_take = rx_valid_i && (state_r == S_RX); // Byte accepted.
  wire [7:0] wpos = cnt_r - `MBT_POS_WDATA; // Offset into write data.
  wire [16:0] end_no = {1'b0, w0_r} + {1'b0, w1_r}; // One past the last register.
  wire [15:0] n2 = {w1_r[14:0], 1'b0}; // Twice the count.
  wire [16:0] walk_sum = {1'b0, w0_r} + {10'h000, k_r}; // Register of this walk step.
  wire is_read = (fc_r == `MBT_FC_READ);
  wire [15:0] rsp_len = exc_r ? `MBT_EXC_LEN :
    is_read ? n2 + `MBT_READ_RSP_TAIL :
    (fc_r == `MBT_FC_WRITE) ? `MBT_WRITE_RSP_LEN : `MBT_ACQ_LEN;
  wire [15:0] total_w = rsp_len + `MBT_HDR_TAIL; // Whole reply in bytes.
  wire [7:0] total = total_w[7:0];
  wire [7:0] rpos = t_r - `MBT_POS_RDATA; // Offset into read data.
  wire hdr_ok = (pid_r == `MBT_PROTO_ID) && (unit_r == `MBT_UNIT_ID) && (cnt_r != 8'hFF) &&
    (len_r >= `MBT_MIN_LEN) && ({8'h00, cnt_r} == len_r + `MBT_HDR_TAIL);

  assign rx_ready_o = (state_r == S_RX);
  assign tx_data_o = tx_byte_r;
  assign tx_valid_o = tx_valid_r;
  assign tx_last_o = tx_last_r;
  assign reg_addr_o = addr_r;
  assign reg_rd_o = rd_r;
  assign reg_wdata_o = wdata_r;
  assign reg_wr_o = wr_r && reg_value_ok_i;
  assign acq_start_o = start_r;
  assign acq_stop_o = stop_r;
  assign acq_fetch_o = fetch_r;

  // ****************************************************************
  // Body check: picks the exception, if any, for a well-headed frame
  // ****************************************************************
  reg chk_exc; // Request body does not conform.
  reg [7:0] chk_code; // Code reported for it.

  // Count faults are checked before number faults, as the usual servers do.
  always @* begin
    chk_exc = 1'b1;
    chk_code = `MBT_EXC_FUNC;
    case (fc_r)
      `MBT_FC_READ: begin
        if (w1_r == 16'h0000 || w1_r > `MBT_READ_MAX || len_r != `MBT_READ_REQ_LEN) begin
          chk_code = `MBT_EXC_COUNT;
        end else if (end_no > `MBT_MAP_WORDS) begin
          chk_code = `MBT_EXC_ADDR;
        end else begin
          chk_exc = 1'b0;
        end
      end
      `MBT_FC_WRITE: begin
        if (w1_r == 16'h0000 || w1_r > `MBT_WRITE_MAX || {8'h00, bc_r} != n2 ||
            len_r != n2 + `MBT_WRITE_REQ_TAIL) begin
          chk_code = `MBT_EXC_COUNT;
        end else if (end_no > `MBT_MAP_WORDS) begin
          chk_code = `MBT_EXC_ADDR;
        end else begin
          chk_exc = 1'b0;
        end
      end
      `MBT_FC_ACQ_CTL: begin
        if (len_r != `MBT_ACQ_LEN || (w0_r != `MBT_ACQ_START && w0_r != `MBT_ACQ_STOP)) begin
          chk_code = `MBT_EXC_COUNT;
        end else begin
          chk_exc = 1'b0;
        end
      end
      `MBT_FC_ACQ_GET: begin
        chk_exc = 1'b0;
      end
      default: begin
        chk_exc = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // Response byte at index t_r, high byte first
  // ****************************************************************
  reg [7:0] rsp_byte; // Byte to load next.
  wire [15:0] proto_w = `MBT_PROTO_ID; // Protocol id sent back.

  always @* begin
    rsp_byte = 8'h00;
    case (t_r)
      `MBT_POS_TID_HI: rsp_byte = tid_r[15:8];
      `MBT_POS_TID_LO: rsp_byte = tid_r[7:0];
      `MBT_POS_PID_HI: rsp_byte = proto_w[15:8];
      `MBT_POS_PID_LO: rsp_byte = proto_w[7:0];
      `MBT_POS_LEN_HI: rsp_byte = rsp_len[15:8];
      `MBT_POS_LEN_LO: rsp_byte = rsp_len[7:0];
      `MBT_POS_UNIT: rsp_byte = `MBT_UNIT_ID;
      `MBT_POS_FC: rsp_byte = exc_r ? (fc_r | `MBT_EXC_FLAG) : fc_r;
      `MBT_POS_W0_HI: rsp_byte = exc_r ? code_r : is_read ? n2[7:0] : w0_r[15:8];
      `MBT_POS_W0_LO: rsp_byte = w0_r[7:0];
      `MBT_POS_W1_HI: rsp_byte = w1_r[15:8];
      `MBT_POS_W1_LO: rsp_byte = w1_r[7:0];
      default: rsp_byte = 8'h00;
    endcase
    if (is_read && !exc_r && t_r >= `MBT_POS_RDATA) begin
      rsp_byte = rpos[0] ? buf_r[rpos[7:1]][7:0] : buf_r[rpos[7:1]][15:8];
    end
  end

  // ****************************************************************
  // Data buffer: filled by write frames and by register reads
  // ****************************************************************
  // Both sources never meet: reads are only issued after reception ends.
  always @(posedge ref_clk_i) begin
    if (rx_take && fc_r == `MBT_FC_WRITE && cnt_r >= `MBT_POS_WDATA &&
        wpos[7:1] < `MBT_BUF_WORDS) begin
      if (wpos[0]) begin
        buf_r[wpos[7:1]][7:0] <= rx_data_i;
      end else begin
        buf_r[wpos[7:1]][15:8] <= rx_data_i;
      end
    end else if (rd_q_r) begin
      buf_r[cap_r] <= reg_rdata_i;
    end
  end

  // ****************************************************************
  // Sequencer: receive, check, walk registers, send
  // ****************************************************************
  always @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= S_RX;
      cnt_r <= 8'h00;
      drop_r <= 1'b0;
      tid_r <= 16'h0000;
      pid_r <= 16'h0000;
      len_r <= 16'h0000;
      unit_r <= 8'h00;
      fc_r <= 8'h00;
      w0_r <= 16'h0000;
      w1_r <= 16'h0000;
      bc_r <= 8'h00;
      exc_r <= 1'b0;
      code_r <= 8'h00;
      k_r <= 7'h00;
      addr_r <= 16'h0000;
      wdata_r <= 16'h0000;
      rd_r <= 1'b0;
      rd_q_r <= 1'b0;
      wr_r <= 1'b0;
      cap_r <= 7'h00;
      t_r <= 8'h00;
      tx_byte_r <= 8'h00;
      tx_valid_r <= 1'b0;
      tx_last_r <= 1'b0;
      start_r <= 1'b0;
      stop_r <= 1'b0;
      fetch_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      stop_r <= 1'b0;
      fetch_r <= 1'b0;
      rd_q_r <= rd_r;
      cap_r <= addr_r[6:0] - w0_r[6:0];
      case (state_r)
        S_RX: begin
          if (rx_take) begin
            cnt_r <= (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;
            if (!conn_up_i) begin
              drop_r <= 1'b1;
            end
            case (cnt_r)
              `MBT_POS_TID_HI: tid_r[15:8] <= rx_data_i;
              `MBT_POS_TID_LO: tid_r[7:0] <= rx_data_i;
              `MBT_POS_PID_HI: pid_r[15:8] <= rx_data_i;
              `MBT_POS_PID_LO: pid_r[7:0] <= rx_data_i;
              `MBT_POS_LEN_HI: len_r[15:8] <= rx_data_i;
              `MBT_POS_LEN_LO: len_r[7:0] <= rx_data_i;
              `MBT_POS_UNIT: unit_r <= rx_data_i;
              `MBT_POS_FC: fc_r <= rx_data_i;
              `MBT_POS_W0_HI: w0_r[15:8] <= rx_data_i;
              `MBT_POS_W0_LO: w0_r[7:0] <= rx_data_i;
              `MBT_POS_W1_HI: w1_r[15:8] <= rx_data_i;
              `MBT_POS_W1_LO: w1_r[7:0] <= rx_data_i;
              `MBT_POS_BC: bc_r <= rx_data_i;
              default: begin
              end
            endcase
            if (rx_last_i) begin
              // A frame that straddled a dropped connection is discarded whole.
              state_r <= (drop_r || !conn_up_i) ? S_RX : S_CHK;
              drop_r <= 1'b0;
            end
          end
        end
        S_CHK: begin
          cnt_r <= 8'h00;
          exc_r <= chk_exc;
          code_r <= chk_code;
          k_r <= 7'h00;
          t_r <= 8'h00;
          if (!hdr_ok || !conn_up_i) begin
            state_r <= S_RX;
          end else if (chk_exc) begin
            state_r <= S_SEND;
          end else if (fc_r == `MBT_FC_ACQ_GET) begin
            fetch_r <= 1'b1;
            state_r <= S_RX;
          end else if (fc_r == `MBT_FC_ACQ_CTL) begin
            start_r <= (w0_r == `MBT_ACQ_START);
            stop_r <= (w0_r == `MBT_ACQ_STOP);
            state_r <= S_SEND;
          end else begin
            state_r <= is_read ? S_FETCH : S_WRITE;
          end
        end
        S_FETCH: begin
          addr_r <= walk_sum[15:0];
          rd_r <= ({9'h000, k_r} < w1_r);
          k_r <= ({9'h000, k_r} < w1_r) ? k_r + 7'h01 : k_r;
          if ({9'h000, k_r} == w1_r && !rd_r && !rd_q_r) begin
            state_r <= S_SEND;
          end
        end
        S_WRITE: begin
          addr_r <= walk_sum[15:0];
          wdata_r <= buf_r[k_r];
          wr_r <= ({9'h000, k_r} < w1_r);
          k_r <= ({9'h000, k_r} < w1_r) ? k_r + 7'h01 : k_r;
          if ({9'h000, k_r} == w1_r && !wr_r) begin
            state_r <= S_SEND;
          end
        end
        S_SEND: begin
          if (!conn_up_i) begin
            tx_valid_r <= 1'b0;
            tx_last_r <= 1'b0;
            state_r <= S_RX;
          end else if (!tx_valid_r || tx_ready_i) begin
            if (t_r < total) begin
              tx_byte_r <= rsp_byte;
              tx_valid_r <= 1'b1;
              tx_last_r <= (t_r == total - 8'h01);
              t_r <= t_r + 8'h01;
            end else begin
              tx_valid_r <= 1'b0;
              tx_last_r <= 1'b0;
              state_r <= S_RX;
            end
          end
        end
        default: begin
          state_r <= S_RX;
        end
      endcase
    end
  end

  // ****************************************************************
  // Idle watchdog on the connection
  // ****************************************************************
  mbt_idle_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .IDLE_MS(IDLE_MS)
  ) u_idle (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_r),
    .conn_up_i(conn_up_i),
    .activity_i(rx_take && rx_last_i),
    .close_o(conn_close_o)
  );

endmodule

/* File: tb/mbt_regspace_model.sv */
// Register space behind the handler, with a simple range rule.
// Assumes one clock; read data follows a read strobe by one cycle.
`timescale 1ns/10ps
module mbt_regspace_model (
  input wire ref_clk_i,
  input wire [15:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output wire value_ok_o
);
  logic [15:0] mem [0:1023]; // Preset to 4000h plus the word number.
  initial begin
    rdata_o = 16'h0000;
    for (int i = 0; i < 1024; i++) mem[i] = 16'h4000 + i[15:0];
  end
  // FFFFh stands for a value outside its permitted range.
  assign value_ok_o = wdata_i != 16'hFFFF;
  // Data is only good for one cycle, then it scrambles so stale reads show.
  always @(posedge ref_clk_i) begin
    if (wr_i) mem[addr_i[9:0]] <= wdata_i;
    if (rd_i) rdata_o <= mem[addr_i[9:0]];
    else rdata_o <= ~rdata_o;
  end
endmodule

/* File: tb/mbt_request_handler_bench.sv */
// Self-checking bench for the request handler.
// Assumes the handler and its register space model are compiled before it.
`timescale 1ns/10ps
module mbt_request_handler_bench;
  logic ref_clk_i = 0, nrst_i = 0, conn_up_i, rx_valid_i, rx_last_i;
  logic tx_ready_i, slow = 0;
  logic [7:0] rx_data_i, fq[$];
  logic [8:0] exp_q[$]; // Expected reply bytes, last flag on top.
  logic [15:0] sh [0:1023], wd [0:63], tid, r;
  logic [31:0] seed = 32'h222B2751;
  wire rx_ready_o, tx_valid_o, tx_last_o, reg_rd_o, reg_wr_o, ok;
  wire acq_start_o, acq_stop_o, acq_fetch_o, conn_close_o;
  wire [7:0] tx_data_o;
  wire [15:0] reg_addr_o, rdata, reg_wdata_o;
  int n_fail = 0, total_checks = 0, cyc = 0, i, m, n_st = 0, n_sp = 0, n_fe = 0, n_cl = 0;
  logic [7:0] xf [5] = '{8'h03, 8'h03, 8'h03, 8'h05, 8'h10};
  logic [15:0] xa [5] = '{16'h0001, 16'h03B6, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] xn [5] = '{16'h0065, 16'h0064, 16'h0000, 16'h0001, 16'h0033};
  logic [7:0] xc [5] = '{8'h03, 8'h02, 8'h03, 8'h01, 8'h03};
  // Short idle limit: 10 x 100 = 1000 cycles.
  mbt_request_handler #(.TICK_CYCLES(17'h0000A), .IDLE_MS(16'h0064)) i_dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .conn_up_i(conn_up_i), .rx_data_i(rx_data_i),
    .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
    .tx_ready_i(tx_ready_i), .reg_addr_o(reg_addr_o), .reg_rd_o(reg_rd_o),
    .reg_rdata_i(rdata), .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o),
    .reg_value_ok_i(ok), .acq_start_o(acq_start_o), .acq_stop_o(acq_stop_o),
    .acq_fetch_o(acq_fetch_o), .conn_close_o(conn_close_o));
  mbt_regspace_model i_regs (.ref_clk_i(ref_clk_i), .addr_i(reg_addr_o), .rd_i(reg_rd_o),
    .wr_i(reg_wr_o), .wdata_i(reg_wdata_o), .rdata_o(rdata), .value_ok_o(ok));
  initial forever #4 ref_clk_i = ~ref_clk_i;
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task conclude();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************************************
  // Watchers: reply bytes against notes, pulse counters, time limit
  // ****************************************************************
  // An unexpected byte is compared against an impossible value.
  always @(posedge ref_clk_i) begin
    cyc++;
    n_st += acq_start_o;
    n_sp += acq_stop_o;
    n_fe += acq_fetch_o;
    n_cl += conn_close_o;
    r = xs();
    tx_ready_i <= !slow || r[2];
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      if (exp_q.size() == 0) check({tx_last_o, tx_data_o}, 16'hFFFF);
      else check({tx_last_o, tx_data_o}, exp_q.pop_front());
    end
    if (cyc == 40000) begin
      n_fail++;
      conclude();
    end
  end
  // ****************************************************************
  // Frame and expectation helpers, high byte first
  // ****************************************************************
  task p16(input logic [15:0] v);
    fq.push_back(v[15:8]);
    fq.push_back(v[7:0]);
  endtask
  task e16(input logic [15:0] v, input logic last);
    exp_q.push_back({1'b0, v[15:8]});
    exp_q.push_back({last, v[7:0]});
  endtask
  task hdr(input logic [15:0] len);
    e16(tid, 0);
    e16(16'h0000, 0);
    e16(len, 0);
    exp_q.push_back(9'h001);
  endtask
  // Builds one request; acquisition codes carry one word only.
  task req(input logic [7:0] fc, input logic [15:0] w0, w1, input logic [7:0] pid, u);
    logic acq;
    acq = fc == 8'h46 || fc == 8'h47;
    tid = xs();
    fq = {};
    p16(tid);
    p16({8'h00, pid});
    p16(fc == 8'h10 ? 16'h0007 + 2 * w1 : (acq ? 16'h0004 : 16'h0006));
    fq.push_back(u);
    fq.push_back(fc);
    p16(w0);
    if (!acq) p16(w1);
    if (fc == 8'h10) begin
      fq.push_back(2 * w1[7:0]);
      for (int k = 0; k < w1; k++) p16(wd[k]);
    end
  endtask
  task rd_exp(input int a, n);
    hdr(16'h0003 + 2 * n[15:0]);
    exp_q.push_back(9'h003);
    exp_q.push_back({1'b0, 2 * n[7:0]});
    for (int k = 0; k < n; k++) e16(sh[a + k], k == n - 1);
  endtask
  // Offers the frame byte by byte, then waits for the reply to drain.
  task go();
    int k;
    for (k = 0; k < fq.size(); k++) begin
      rx_data_i <= fq[k];
      rx_valid_i <= 1;
      rx_last_i <= k == fq.size() - 1;
      @(negedge ref_clk_i);
      while (!rx_ready_o) @(negedge ref_clk_i);
      @(posedge ref_clk_i);
    end
    rx_valid_i <= 0;
    rx_last_i <= 0;
    repeat (20) @(negedge ref_clk_i);
    k = 0;
    while ((exp_q.size() != 0 || !rx_ready_o) && k < 3000) begin
      @(negedge ref_clk_i);
      k++;
    end
    check(exp_q.size(), 0);
    @(posedge ref_clk_i);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {conn_up_i, rx_valid_i, rx_last_i, rx_data_i} <= 11'h000;
    for (i = 0; i < 1024; i++) sh[i] = 16'h4000 + i[15:0];
    for (i = 0; i < 64; i++) wd[i] = xs() & 16'h7FFF;
    repeat (10) @(posedge ref_clk_i);
    nrst_i <= 1;
    conn_up_i <= 1;
    repeat (4) @(posedge ref_clk_i);
    wd[1] = 16'hFFFF;
    req(8'h10, 16'h000A, 16'h0002, 8'h00, 8'h01);
    hdr(16'h0006);
    exp_q.push_back(9'h010);
    e16(16'h000A, 0);
    e16(16'h0002, 1);
    sh[10] = wd[0];
    go();
    req(8'h03, 16'h0009, 16'h0003, 8'h00, 8'h01);
    rd_exp(9, 3);
    go();
    slow = 1;
    req(8'h03, 16'h0384, 16'h0064, 8'h00, 8'h01);
    rd_exp(900, 100);
    go();
    for (i = 0; i < 5; i++) begin
      req(xf[i], xa[i], xn[i], 8'h00, 8'h01);
      hdr(16'h0003);
      exp_q.push_back({1'b0, xf[i] | 8'h80});
      exp_q.push_back({1'b1, xc[i]});
      go();
    end
    req(8'h03, 16'h0000, 16'h0002, 8'h00, 8'h01);
    rd_exp(0, 2);
    go();
    slow = 0;
    for (i = 1; i < 4; i++) begin
      req(8'h46, i[15:0], 16'h0000, 8'h00, 8'h01);
      hdr(i < 3 ? 16'h0004 : 16'h0003);
      exp_q.push_back(i < 3 ? 9'h046 : 9'h0C6);
      if (i < 3) e16(i[15:0], 1);
      else exp_q.push_back(9'h103);
      go();
    end
    check(n_st, 1);
    check(n_sp, 1);
    req(8'h47, 16'h0001, 16'h0000, 8'h00, 8'h01);
    go();
    check(n_fe, 1);
    req(8'h03, 16'h0000, 16'h0001, 8'h01, 8'h01);
    go();
    req(8'h03, 16'h0000, 16'h0001, 8'h00, 8'h02);
    go();
    conn_up_i <= 0;
    req(8'h03, 16'h0000, 16'h0001, 8'h00, 8'h01);
    go();
    conn_up_i <= 1;
    m = n_cl;
    repeat (950) @(posedge ref_clk_i);
    check(n_cl - m, 0);
    repeat (150) @(posedge ref_clk_i);
    check(n_cl - m, 1);
    repeat (1100) @(posedge ref_clk_i);
    check(n_cl - m, 1);
    conclude();
  end
endmodule
bind mbt_request_handler mbt_request_handler_chk i_chk (.ref_clk_i(ref_clk_i),
  .nrst_i(nrst_i), .conn_up_i(conn_up_i), .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o),
  .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
  .reg_addr_o(reg_addr_o), .reg_rd_o(reg_rd_o), .reg_wr_o(reg_wr_o),
  .reg_value_ok_i(reg_value_ok_i), .acq_start_o(acq_start_o), .acq_stop_o(acq_stop_o),
  .acq_fetch_o(acq_fetch_o), .conn_close_o(conn_close_o));

/* File: tb/mbt_request_handler_chk.sv */
// Checker for the request handler; it watches only the top module's ports.
// Assumes it is bound into the handler and shares its clock and reset.
`timescale 1ns/10ps
module mbt_request_handler_chk (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire conn_up_i,
  input wire rx_ready_o,
  input wire [7:0] tx_data_o,
  input wire tx_valid_o,
  input wire tx_last_o,
  input wire tx_ready_i,
  input wire [15:0] reg_addr_o,
  input wire reg_rd_o,
  input wire reg_wr_o,
  input wire reg_value_ok_i,
  input wire acq_start_o,
  input wire acq_stop_o,
  input wire acq_fetch_o,
  input wire conn_close_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  // One domain, so clock and reset are stated once.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // A reply byte must not change until the host takes it.
  property p_tx_hold;
    conn_up_i && tx_valid_o && !tx_ready_i ##1 conn_up_i |->
      tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte changed while stalled");
  property p_last_valid;
    tx_last_o |-> tx_valid_o;
  endproperty
  a_last_valid: assert property (p_last_valid) else $error("last flag without valid");
  property p_one_txn;
    tx_valid_o |-> !rx_ready_o;
  endproperty
  a_one_txn: assert property (p_one_txn) else $error("request taken during reply");
  // A link that has been down for two cycles carries no reply.
  property p_no_link;
    !conn_up_i [*2] |-> !tx_valid_o;
  endproperty
  a_no_link: assert property (p_no_link) else $error("reply without connection");
  property p_rd_range;
    reg_rd_o |-> reg_addr_o < 16'h03E8 && !rx_ready_o;
  endproperty
  a_rd_range: assert property (p_rd_range) else $error("read outside map or phase");
  // The write strobe is suppressed for values out of range.
  property p_wr_ok;
    reg_wr_o |-> reg_value_ok_i && !rx_ready_o;
  endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("write of rejected value");
  property p_acq_excl;
    acq_start_o |-> !acq_stop_o && !acq_fetch_o;
  endproperty
  a_acq_excl: assert property (p_acq_excl) else $error("start with another action");
  property p_acq_pulse;
    acq_start_o |=> !acq_start_o;
  endproperty
  a_acq_pulse: assert property (p_acq_pulse) else $error("start pulse too long");
  property p_close_once;
    conn_close_o |=> !conn_close_o [*8];
  endproperty
  a_close_once: assert property (p_close_once) else $error("close pulse repeated");
endmodule
